// [jog_pkg.sv]
package jog_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STATE_OFS = 12'h004;
    localparam logic [11:0] IRQ_STAT_OFS = 12'h008;
    localparam logic [11:0] IRQ_MASK_OFS = 12'h00C;

    localparam int unsigned CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RESET = 1'h1;

    localparam int unsigned EV_DONE = 0;
    localparam int unsigned EV_ABORT = 1;
    localparam int unsigned EV_ERROR = 2;
    localparam int unsigned EV_SPEED = 3;
    localparam int unsigned EV_W = 4;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

    localparam int unsigned FLAGS_LSB = 0;
    localparam int unsigned FLAGS_W = 5;
    localparam int unsigned STATE_LSB = 8;
    localparam int unsigned STATE_W = 2;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_DECEL
    } task_state_e;

    typedef struct packed {
        logic busy;
        logic at_speed;
        logic aborted;
        logic error;
        logic decel;
    } flags_s;

endpackage

// [edge_detect.sv]
`timescale 1ns/1ns
`default_nettype none

module edge_detect
    import jog_pkg::*;
#(
    parameter int unsigned W = 2
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] level,
    output logic [W-1:0] rise
);

    logic [W-1:0] last_reg;
    logic [W-1:0] last_next;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_comb begin
                last_next[i] = level[i];
                rise[i] = level[i] & ~last_reg[i];
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            last_reg <= '0;
        end else begin
            last_reg <= last_next;
        end
    end

endmodule

`default_nettype wire

// [jog_task_status_control.sv]
`timescale 1ns/1ns
`default_nettype none

// Function
// - A rising edge on either jog request starts the jog task.
// - Busy stays high for the whole time the jog task is active.
// - At-speed rises on reaching set velocity, stays only while at it.
// - Dropping the jog request starts deceleration and clears at-speed.
// - Task completes when both requests are low and axis stands still.
// - Busy falls whenever the task completes, is aborted or errors out.
// - A superseding task with no error in the same cycle clears busy and sets aborted in one cycle.
// - An error clears busy and sets the error flag in one cycle.
// - Aborted and error show one cycle, latch while a request stays high.
// - Abort while decelerating with requests low pulses aborted one cycle.
// - Error while decelerating with requests low pulses error one cycle.
// - Abort and error report alike whether or not speed was reached.
module jog_task_status_control
    import jog_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic JOG_FWD_REQUEST,
    input wire logic JOG_REV_REQUEST,
    input wire logic AT_VELOCITY,
    input wire logic STANDSTILL,
    input wire logic SUPERSEDE,
    input wire logic AXIS_FAULT,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic BUSY,
    output logic AT_SPEED_FLAG,
    output logic SUPERSEDED_FLAG,
    output logic ERROR_FLAG,
    output logic DECEL_CMD,
    output logic IRQ
);

    ////////////////////////////////////////////////////////////////////////
    logic [1:0] req_rise;
    logic any_req;
    logic start;
    task_state_e state_reg;
    task_state_e state_next;
    flags_s flags_reg;
    flags_s flags_next;
    logic ctrl_en_reg;
    logic ctrl_en_next;
    logic [EV_W-1:0] stat_reg;
    logic [EV_W-1:0] stat_next;
    logic [EV_W-1:0] mask_reg;
    logic [EV_W-1:0] mask_next;
    logic irq_reg;
    logic irq_next;
    logic [EV_W-1:0] events;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic setup;
    logic wr_done;
    logic rd_stat;
    logic mapped;

    edge_detect #(
        .W(2)
    ) u_req_edge (
        .clk(REF_CLK),
        .rstn(RSTN),
        .level({JOG_REV_REQUEST, JOG_FWD_REQUEST}),
        .rise(req_rise)
    );

    assign any_req = JOG_FWD_REQUEST | JOG_REV_REQUEST;
    // Software can hold off new jog tasks; a running one is not disturbed.
    assign start = (|req_rise) & ctrl_en_reg;

    ////////////////////////////////////////////////////////////////////////
    // Task sequencing and output flags. An error outranks an abort when
    // both arrive together, so no abort is reported in that cycle.
    always_comb begin
        state_next = state_reg;
        flags_next = flags_reg;
        events = '0;
        flags_next.aborted = flags_reg.aborted & any_req;
        flags_next.error = flags_reg.error & any_req;
        case (state_reg)
            ST_IDLE: begin
                if (start) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!any_req) begin
                    state_next = ST_DECEL;
                end
            end
            ST_DECEL: begin
                if (start) begin
                    state_next = ST_RUN;
                end else if (!any_req && STANDSTILL) begin
                    state_next = ST_IDLE;
                    events[EV_DONE] = 1'h1;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // Abort and error do not look at the at-speed flag at all.
        if (state_reg != ST_IDLE && AXIS_FAULT) begin
            state_next = ST_IDLE;
            flags_next.error = 1'h1;
            events[EV_ERROR] = 1'h1;
        end else if (state_reg != ST_IDLE && SUPERSEDE) begin
            state_next = ST_IDLE;
            flags_next.aborted = 1'h1;
            events[EV_ABORT] = 1'h1;
        end
        flags_next.busy = (state_next != ST_IDLE);
        flags_next.decel = (state_next == ST_DECEL);
        // Only steady travel under a running task counts as at speed.
        flags_next.at_speed = (state_next == ST_RUN) && any_req &&
            AT_VELOCITY;
        events[EV_SPEED] = flags_next.at_speed & ~flags_reg.at_speed;
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_reg <= ST_IDLE;
            flags_reg <= '0;
        end else begin
            state_reg <= state_next;
            flags_reg <= flags_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave. The answer is prepared in the setup cycle so that PREADY
    // and PRDATA come from flops; every access therefore has one wait-free
    // access cycle.
    assign setup = PSEL & ~PENABLE;
    assign wr_done = PSEL & PENABLE & pready_reg & PWRITE;
    assign rd_stat = PSEL & PENABLE & pready_reg & ~PWRITE &
        (PADDR == IRQ_STAT_OFS);
    assign mapped = (PADDR == CTRL_OFS) || (PADDR == STATE_OFS) ||
        (PADDR == IRQ_STAT_OFS) || (PADDR == IRQ_MASK_OFS);

    always_comb begin
        ctrl_en_next = ctrl_en_reg;
        mask_next = mask_reg;
        pready_next = setup;
        pslverr_next = setup & ~mapped;
        prdata_next = '0;
        if (setup && !PWRITE) begin
            case (PADDR)
                CTRL_OFS: prdata_next[CTRL_EN_BIT] = ctrl_en_reg;
                STATE_OFS: begin
                    prdata_next[FLAGS_LSB +: FLAGS_W] = flags_reg;
                    prdata_next[STATE_LSB +: STATE_W] = state_reg;
                end
                IRQ_STAT_OFS: prdata_next[EV_W-1:0] = stat_reg;
                IRQ_MASK_OFS: prdata_next[EV_W-1:0] = mask_reg;
                default: prdata_next = '0;
            endcase
        end
        if (wr_done && PADDR == CTRL_OFS) begin
            ctrl_en_next = PWDATA[CTRL_EN_BIT];
        end
        if (wr_done && PADDR == IRQ_MASK_OFS) begin
            mask_next = PWDATA[EV_W-1:0];
        end
        // Only the bits that the read reported are cleared, so an event
        // landing between the setup and the access edge is not lost.
        stat_next = (rd_stat ? stat_reg & ~prdata_reg[EV_W-1:0] : stat_reg)
            | events;
        irq_next = |(stat_next & mask_next);
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_en_reg <= CTRL_EN_RESET;
            mask_reg <= IRQ_MASK_RESET;
            stat_reg <= '0;
            irq_reg <= 1'h0;
            prdata_reg <= '0;
            pready_reg <= 1'h0;
            pslverr_reg <= 1'h0;
        end else begin
            ctrl_en_reg <= ctrl_en_next;
            mask_reg <= mask_next;
            stat_reg <= stat_next;
            irq_reg <= irq_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign PRDATA = prdata_reg;
    assign PREADY = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign BUSY = flags_reg.busy;
    assign AT_SPEED_FLAG = flags_reg.at_speed;
    assign SUPERSEDED_FLAG = flags_reg.aborted;
    assign ERROR_FLAG = flags_reg.error;
    assign DECEL_CMD = flags_reg.decel;
    assign IRQ = irq_reg;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RSTN);

    sequence idle_start;
        state_reg == ST_IDLE && start && !AXIS_FAULT && !SUPERSEDE;
    endsequence

    sequence decel_low_abort;
        state_reg == ST_DECEL && !any_req && SUPERSEDE && !AXIS_FAULT;
    endsequence

    sequence decel_low_fault;
        state_reg == ST_DECEL && !any_req && AXIS_FAULT;
    endsequence

    sequence quiet;
        !any_req && !start;
    endsequence

    task_start_a: assert property (
        idle_start |=> BUSY && !DECEL_CMD
    ) else $error("jog start did not raise busy");

    busy_active_a: assert property (
        state_reg != ST_IDLE |-> BUSY
    ) else $error("busy low while task active");

    speed_cause_a: assert property (
        $rose(AT_SPEED_FLAG) |-> $past(AT_VELOCITY) && $past(any_req)
    ) else $error("at-speed rose without velocity reached");

    decel_entry_a: assert property (
        state_reg == ST_RUN && !any_req && !AXIS_FAULT && !SUPERSEDE
        |=> DECEL_CMD && BUSY && !AT_SPEED_FLAG
    ) else $error("request drop did not start deceleration");

    task_done_a: assert property (
        state_reg == ST_DECEL && !any_req && STANDSTILL && !start
        |=> !BUSY && !DECEL_CMD ##1 (!BUSY || $past(start))
    ) else $error("task did not complete at standstill");

    abort_report_a: assert property (
        state_reg != ST_IDLE && SUPERSEDE && !AXIS_FAULT
        |=> !BUSY && SUPERSEDED_FLAG && !AT_SPEED_FLAG
    ) else $error("abort not reported in one cycle");

    error_report_a: assert property (
        state_reg != ST_IDLE && AXIS_FAULT
        |=> !BUSY && ERROR_FLAG && !$rose(SUPERSEDED_FLAG) && !AT_SPEED_FLAG
    ) else $error("error not reported in one cycle");

    flag_latch_a: assert property (
        (ERROR_FLAG || SUPERSEDED_FLAG) && any_req
        |=> (ERROR_FLAG || !$past(ERROR_FLAG)) &&
            (SUPERSEDED_FLAG || !$past(SUPERSEDED_FLAG))
    ) else $error("status flag dropped while request held");

    flag_release_a: assert property (
        ERROR_FLAG && !any_req && state_reg == ST_IDLE |=> !ERROR_FLAG
    ) else $error("error flag kept after request released");

    abort_pulse_a: assert property (
        decel_low_abort ##1 quiet |-> SUPERSEDED_FLAG ##1 !SUPERSEDED_FLAG
    ) else $error("abort during deceleration not a single pulse");

    error_pulse_a: assert property (
        decel_low_fault ##1 quiet |-> ERROR_FLAG ##1 !ERROR_FLAG
    ) else $error("error during deceleration not a single pulse");

    irq_level_a: assert property (
        IRQ == |(stat_reg & mask_reg)
    ) else $error("interrupt does not match masked status");

endmodule

`default_nettype wire

// [axis_model.sv]
`timescale 1ns/1ns
`default_nettype none

// Axis stand-in: speed ramps up while the task runs and down otherwise.
module axis_model #(
    parameter int RAMP = 6
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic run,
    output logic at_velocity,
    output logic standstill
);
    int spd;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            spd <= 0;
        end else if (run && spd < RAMP) begin
            spd <= spd + 1;
        end else if (!run && spd > 0) begin
            spd <= spd - 1;
        end
    end
    assign at_velocity = run && (spd == RAMP);
    assign standstill = (spd == 0);
endmodule

`default_nettype wire

// [tb_jog_task_status_control.sv]
`timescale 1ns/1ns
`default_nettype none

module tb_jog_task_status_control
    import jog_pkg::*;
;
    typedef struct packed {
        logic rev;
        logic early;
        logic sup;
        logic flt;
        logic [4:0] fl;
    } row_s;
    logic ref_clk = 1'b0, rstn = 1'b0, fwd = 1'b0, rev = 1'b0;
    logic sup = 1'b0, flt = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, slverr_seen;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, busy, at_spd, abt, err, decel, irq, at_vel, still;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    row_s rows [7] = '{'{0, 0, 0, 0, 5'h00}, '{1, 0, 0, 0, 5'h00},
        '{0, 0, 1, 0, 5'h04}, '{1, 0, 0, 1, 5'h02}, '{0, 1, 1, 0, 5'h04},
        '{1, 1, 0, 1, 5'h02}, '{0, 0, 1, 1, 5'h02}};

    jog_task_status_control jog_task_status_control_i (
        .REF_CLK(ref_clk), .RSTN(rstn), .JOG_FWD_REQUEST(fwd),
        .JOG_REV_REQUEST(rev), .AT_VELOCITY(at_vel), .STANDSTILL(still),
        .SUPERSEDE(sup), .AXIS_FAULT(flt), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .BUSY(busy),
        .AT_SPEED_FLAG(at_spd), .SUPERSEDED_FLAG(abt), .ERROR_FLAG(err),
        .DECEL_CMD(decel), .IRQ(irq));
    axis_model axis_model_i (.clk(ref_clk), .rstn(rstn),
        .run(busy && !decel), .at_velocity(at_vel), .standstill(still));

    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // The request stands until PREADY is seen high at a rising edge; the
    // answer is taken at that edge and only then is the bus released.
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        rd = prdata;
        slverr_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic look(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic settle();
        for (int i = 0; i < 40 && (still !== 1'b1 || busy !== 1'b0); i++)
            @(negedge ref_clk);
    endtask

    function automatic logic [4:0] fl();
        return {busy, at_spd, abt, err, decel};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        @(negedge ref_clk);
        chk("reset flags", {fl(), irq}, 6'h00);
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        apb(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl", rd, 32'h1);
        apb(1'b0, IRQ_MASK_OFS, 32'h0);
        chk("mask", rd, 32'h0);
        foreach (rows[k]) begin
            @(posedge ref_clk);
            fwd <= !rows[k].rev;
            rev <= rows[k].rev;
            look(1);
            chk("busy", busy, 1'b1);
            if (!rows[k].early) begin
                for (int i = 0; i < 30 && at_spd !== 1'b1; i++)
                    @(negedge ref_clk);
                chk("at_speed", at_spd, 1'b1);
            end
            @(posedge ref_clk);
            if (rows[k].sup | rows[k].flt) begin
                sup <= rows[k].sup;
                flt <= rows[k].flt;
                @(posedge ref_clk);
                sup <= 1'b0;
                flt <= 1'b0;
                look(0);
                chk("flags", fl(), rows[k].fl);
                look(3);
                chk("held", fl(), rows[k].fl);
                @(posedge ref_clk);
            end
            fwd <= 1'b0;
            rev <= 1'b0;
            look(1);
            if (rows[k].sup | rows[k].flt) begin
                chk("cleared", fl(), 5'h00);
            end else begin
                chk("decel", fl(), 5'h11);
                for (int i = 0; i < 30 && busy !== 1'b0; i++)
                    @(negedge ref_clk);
                chk("done", {fl(), still}, 6'h01);
            end
            settle();
        end
        chk("masked irq", irq, 1'b0);
        apb(1'b0, IRQ_STAT_OFS, 32'h0);
        chk("irq_stat", rd, 32'hF);
        apb(1'b0, IRQ_STAT_OFS, 32'h0);
        chk("irq_stat clear", rd, 32'h0);
        apb(1'b1, IRQ_MASK_OFS, 32'h6);
        // Events land while decelerating with both requests already low.
        for (int k = 0; k < 2; k++) begin
            @(posedge ref_clk);
            fwd <= 1'b1;
            for (int i = 0; i < 30 && at_spd !== 1'b1; i++)
                @(negedge ref_clk);
            @(posedge ref_clk);
            fwd <= 1'b0;
            @(posedge ref_clk);
            sup <= (k == 0);
            flt <= (k == 1);
            @(posedge ref_clk);
            sup <= 1'b0;
            flt <= 1'b0;
            look(0);
            chk("pulse", fl(), (k == 1) ? 5'h02 : 5'h04);
            look(1);
            chk("pulse end", fl(), 5'h00);
            chk("irq", irq, 1'b1);
            apb(1'b0, IRQ_STAT_OFS, 32'h0);
            chk("irq_stat ev", rd & 32'h6, (k == 1) ? 32'h4 : 32'h2);
            look(1);
            chk("irq clear", irq, 1'b0);
            settle();
        end
        // A fresh edge while the axis still slows down restarts the task.
        @(posedge ref_clk);
        fwd <= 1'b1;
        look(2);
        @(posedge ref_clk);
        fwd <= 1'b0;
        look(1);
        chk("slowing", {busy, decel}, 2'h3);
        @(posedge ref_clk);
        fwd <= 1'b1;
        look(1);
        chk("restarted", {busy, decel}, 2'h2);
        @(posedge ref_clk);
        fwd <= 1'b0;
        settle();
        chk("restart done", {busy, still}, 2'h1);
        apb(1'b1, CTRL_OFS, 32'h0);
        @(posedge ref_clk);
        fwd <= 1'b1;
        look(2);
        chk("disabled", busy, 1'b0);
        @(posedge ref_clk);
        fwd <= 1'b0;
        apb(1'b1, CTRL_OFS, 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        chk("slverr", slverr_seen, 1'b1);
        chk("unmapped", rd, 32'h0);
        apb(1'b0, STATE_OFS, 32'h0);
        chk("state", rd, 32'h0);
        // A request still high across reset counts as a fresh start.
        @(posedge ref_clk);
        fwd <= 1'b1;
        look(2);
        @(posedge ref_clk);
        rstn <= 1'b0;
        look(0);
        chk("mid reset", fl(), 5'h00);
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        look(1);
        chk("restart", busy, 1'b1);
        finish_test();
    end
endmodule

`default_nettype wire
